/* include/ptxfc_defines.svh */
`ifndef PTXFC_DEFINES_SVH
`define PTXFC_DEFINES_SVH

// field lengths
`define PTXFC_HDR_FLUSH_LEN   4'h6
`define PTXFC_PAY_FLUSH_LEN   4'h8
`define PTXFC_FRAG_STEP       9'h028
`define PTXFC_FRAG_FIVE_PLUS  9'h008
`define PTXFC_PAD_STEP        3'h2
`define PTXFC_PAD_WRAP        3'h4
// coder and scrambler
`define PTXFC_CONV_G0         7'h79
`define PTXFC_CONV_G1         7'h5b
`define PTXFC_PN_SEED         7'h7f
`define PTXFC_PN_TAP_A        3
`define PTXFC_PN_TAP_B        6

`endif

/* include/ptxfc_pkg.sv */
package ptxfc_pkg;

  // one output bit with its field boundary marks
  typedef struct packed {
    logic bit_val;
    logic is_header;
    logic frame_last;
  } ptxfc_sym_t;

  // per-frame settings captured at start
  typedef struct packed {
    logic       conv_coding_flag;
    logic [3:0] active_channel_count;
    logic [15:0] pad_len;
  } ptxfc_cfg_t;

  // frame phases
  typedef enum logic [2:0] {
    PH_IDLE,
    PH_HDR_INFO,
    PH_HDR_FRAG,
    PH_HDR_FLUSH,
    PH_HDR_PAD,
    PH_PAY,
    PH_PAY_FLUSH,
    PH_PAY_PAD
  } ptxfc_phase_t;

endpackage : ptxfc_pkg

/* verilog/ptxfc_scrambler.sv */
`timescale 1ns/1ps
`include "ptxfc_defines.svh"

module ptxfc_scrambler (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // control
  input  wire logic restart,
  input  wire logic in_valid,
  input  wire logic in_bit,
  // output
  output logic      out_bit,
  output logic      pseudo_noise_seq
);

  logic [6:0] lfsr;
  logic       fb;

  // x^7 + x^4 + 1: stages four and seven feed back and give the pn bit
  assign fb               = lfsr[`PTXFC_PN_TAP_A] ^ lfsr[`PTXFC_PN_TAP_B];
  assign pseudo_noise_seq = fb;
  assign out_bit          = in_bit ^ fb;

  // reload on restart so every frame sees the same 127-bit sequence
  always_ff @(posedge clk) begin
    if (rst) begin
      lfsr <= `PTXFC_PN_SEED;
    end else if (ce) begin
      if (restart) begin
        lfsr <= `PTXFC_PN_SEED;
      end else if (in_valid) begin
        lfsr <= {lfsr[5:0], fb};
      end
    end
  end

endmodule : ptxfc_scrambler

/* verilog/ptxfc_frame_coder.sv */
`timescale 1ns/1ps
`include "ptxfc_defines.svh"


module ptxfc_frame_coder #(
  // header info bits ahead of the fragment: protocol 4, length 8, pad length 9,
  // reserved 3 and header check 12; with flush and pad the header input then
  // comes to 42 bits per active channel, a whole number of coded symbols
  parameter int HDR_INFO_LEN = 36
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               ce,
  // frame control
  input  wire logic               start,
  input  wire ptxfc_pkg::ptxfc_cfg_t cfg,
  output logic                    busy,
  // source bits, msb first within each field
  input  wire logic               src_valid,
  input  wire logic               src_bit,
  input  wire logic               src_last,
  output logic                    src_ready,
  // coded and scrambled bits toward the interleaver
  output ptxfc_pkg::ptxfc_sym_t   out_sym,
  output logic                    out_valid,
  input  wire logic               out_ready
);

  // ==========================================================
  // frame sequencing
  // ==========================================================
  ptxfc_pkg::ptxfc_phase_t phase;
  ptxfc_pkg::ptxfc_cfg_t   cur;
  logic [15:0]             cnt;
  logic [8:0]              frag_len;
  logic [2:0]              hpad_len;
  logic [2:0]              chm1;
  logic                    src_end;

  // length table indexed by channel count minus one; eight constant entries
  // keep the multiply out of the per-frame path
  localparam int CH_ENTRIES = 2 ** $bits(chm1);
  logic [8:0] frag_tab [CH_ENTRIES];
  logic [2:0] hpad_tab [CH_ENTRIES];

  for (genvar g = 0; g < CH_ENTRIES; g++) begin : g_len_tab
    localparam logic [2:0] IDX = 3'(g);
    // 40 bits per extra channel, with an 8-bit jump from five channels on
    assign frag_tab[g] = 9'(IDX * `PTXFC_FRAG_STEP) +
                         ((IDX >= 3'h4) ? `PTXFC_FRAG_FIVE_PLUS : 9'h000);
    // header pad keeps the coded header on whole symbols: 0, 2, 4, 6, repeating
    assign hpad_tab[g] = 3'((IDX % `PTXFC_PAD_WRAP) * `PTXFC_PAD_STEP);
  end

  // a count of zero is outside the range and reads the eight-channel entry
  assign chm1     = 3'(cur.active_channel_count - 4'h1);
  assign frag_len = frag_tab[chm1];
  assign hpad_len = hpad_tab[chm1];

  logic coded_phase;
  logic src_phase;
  logic step;
  logic in_bit;
  logic half;
  logic last_bit_of_phase;
  logic [15:0] phase_len;
  logic use_held;
  logic held_bit;
  logic held_last;

  // header always coded; payload only when the flag is on
  // busy comes straight from the phase register and falls with the last step
  assign coded_phase = (phase == ptxfc_pkg::PH_HDR_INFO) || (phase == ptxfc_pkg::PH_HDR_FRAG) ||
                       (phase == ptxfc_pkg::PH_HDR_FLUSH) || (phase == ptxfc_pkg::PH_HDR_PAD) ||
                       cur.conv_coding_flag;
  assign src_phase   = (phase == ptxfc_pkg::PH_HDR_INFO) || (phase == ptxfc_pkg::PH_HDR_FRAG) ||
                       (phase == ptxfc_pkg::PH_PAY);
  assign busy        = (phase != ptxfc_pkg::PH_IDLE);

  // a source bit is taken on the first half of a coded pair; the second half
  // runs from the held copy, so the source may already show its next bit
  assign use_held  = coded_phase && half;
  assign src_ready = src_phase && out_ready && ce && !use_held;
  assign out_valid = busy && (!src_phase || use_held || src_valid);
  assign step      = ce && out_valid && out_ready;

  // zeros for flush and pad fields; source bits pass in msb-first order
  assign in_bit = !src_phase ? 1'b0 :
                  (use_held ? held_bit : src_bit);

  // copy of the taken source bit and its last mark for the second coded half;
  // hazard: without it the second half would code the source's next bit
  always_ff @(posedge clk) begin
    if (rst) begin
      held_bit  <= 1'b0;
      held_last <= 1'b0;
    end else if (ce) begin
      if (src_valid && src_ready) begin
        held_bit  <= src_bit;
        held_last <= src_last;
      end
    end
  end

  // field length in input bits; the payload ends on the source's last mark
  // instead, so its entry is never reached by the counter
  always_comb begin
    unique case (phase)
      ptxfc_pkg::PH_HDR_INFO:  phase_len = 16'(HDR_INFO_LEN);
      ptxfc_pkg::PH_HDR_FRAG:  phase_len = 16'(frag_len);
      ptxfc_pkg::PH_HDR_FLUSH: phase_len = 16'(`PTXFC_HDR_FLUSH_LEN);
      ptxfc_pkg::PH_HDR_PAD:   phase_len = 16'(hpad_len);
      ptxfc_pkg::PH_PAY_FLUSH: phase_len = 16'(`PTXFC_PAY_FLUSH_LEN);
      ptxfc_pkg::PH_PAY_PAD:   phase_len = cur.pad_len;
      default:                 phase_len = 16'hffff;
    endcase
  end

  // an input bit completes once its second coded bit leaves; an uncoded bit
  // completes on its only step
  logic bit_done;
  assign bit_done          = step && (!coded_phase || half);
  assign src_end           = (phase == ptxfc_pkg::PH_PAY) &&
                             (use_held ? held_last : src_last);
  assign last_bit_of_phase = (phase == ptxfc_pkg::PH_PAY) ? src_end : (cnt + 16'h1 >= phase_len);

  // next phase, skipping fields of zero length: info, fragment, flush, header
  // pad, payload, payload flush when coded, payload pad, then idle again
  function automatic ptxfc_pkg::ptxfc_phase_t after(input ptxfc_pkg::ptxfc_phase_t p,
                                                    input logic coded,
                                                    input logic [8:0] fl,
                                                    input logic [2:0] hl,
                                                    input logic [15:0] pl);
    ptxfc_pkg::ptxfc_phase_t n;
    n = ptxfc_pkg::PH_IDLE;
    unique case (p)
      ptxfc_pkg::PH_HDR_INFO:  n = (fl != 9'h000) ? ptxfc_pkg::PH_HDR_FRAG
                                                   : ptxfc_pkg::PH_HDR_FLUSH;
      ptxfc_pkg::PH_HDR_FRAG:  n = ptxfc_pkg::PH_HDR_FLUSH;
      ptxfc_pkg::PH_HDR_FLUSH: n = (hl != 3'h0) ? ptxfc_pkg::PH_HDR_PAD : ptxfc_pkg::PH_PAY;
      ptxfc_pkg::PH_HDR_PAD:   n = ptxfc_pkg::PH_PAY;
      ptxfc_pkg::PH_PAY:       n = coded ? ptxfc_pkg::PH_PAY_FLUSH :
                                   ((pl != 16'h0000) ? ptxfc_pkg::PH_PAY_PAD
                                                     : ptxfc_pkg::PH_IDLE);
      ptxfc_pkg::PH_PAY_FLUSH: n = (pl != 16'h0000) ? ptxfc_pkg::PH_PAY_PAD
                                                    : ptxfc_pkg::PH_IDLE;
      ptxfc_pkg::PH_PAY_PAD:   n = ptxfc_pkg::PH_IDLE;
      ptxfc_pkg::PH_IDLE:      n = ptxfc_pkg::PH_IDLE;
    endcase
    return n;
  endfunction : after

  // pad follows the flush; trade-off: zeros after the flush still keep the coder at zero
  ptxfc_pkg::ptxfc_phase_t next_phase;
  assign next_phase = after(phase, cur.conv_coding_flag, frag_len, hpad_len, cur.pad_len);

  // frame settings are captured once, at the start, and held for the whole
  // frame, so a change of cfg in mid-frame has no effect
  always_ff @(posedge clk) begin
    if (rst) begin
      cur <= '0;
    end else if (ce) begin
      if ((phase == ptxfc_pkg::PH_IDLE) && start) begin
        cur <= cfg;
      end
    end
  end

  // phase register; start is only looked at while idle, so a held start is harmless
  always_ff @(posedge clk) begin
    if (rst) begin
      phase <= ptxfc_pkg::PH_IDLE;
    end else if (ce) begin
      if (phase == ptxfc_pkg::PH_IDLE) begin
        if (start) begin
          phase <= ptxfc_pkg::PH_HDR_INFO;
        end
      end else if (bit_done && last_bit_of_phase) begin
        phase <= next_phase;
      end
    end
  end

  // per-field input bit counter, cleared between fields and while idle
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= 16'h0000;
    end else if (ce) begin
      if (phase == ptxfc_pkg::PH_IDLE) begin
        cnt <= 16'h0000;
      end else if (bit_done) begin
        if (last_bit_of_phase) begin
          cnt <= 16'h0000;
        end else begin
          cnt <= cnt + 16'h0001;
        end
      end
    end
  end

  // ==========================================================
  // convolutional encoder
  // ==========================================================
  // rate one-half coder: each input bit leaves as two coded bits, generator
  // 1111001 first; the newest bit sits in window[6] to match the mask order
  logic [5:0] conv_sr;
  logic [6:0] window;
  logic       g0_bit;
  logic       g1_bit;
  logic       coded_bit;

  // window holds the newest bit in the top position
  assign window = {in_bit, conv_sr};
  assign g0_bit = ^(window & `PTXFC_CONV_G0);
  assign g1_bit = ^(window & `PTXFC_CONV_G1);
  assign coded_bit = !coded_phase ? in_bit : (half ? g1_bit : g0_bit);

  // pair toggle: low for the first coded bit of an input bit, high for the second;
  // a coded field only changes on the second half, so pairs never straddle two fields
  always_ff @(posedge clk) begin
    if (rst) begin
      half <= 1'b0;
    end else if (ce) begin
      if (phase == ptxfc_pkg::PH_IDLE) begin
        half <= 1'b0;
      end else if (step && coded_phase) begin
        half <= !half;
      end
    end
  end

  // shift once the second coded bit has left; cleared at each frame start
  always_ff @(posedge clk) begin
    if (rst) begin
      conv_sr <= 6'h00;
    end else if (ce) begin
      if (phase == ptxfc_pkg::PH_IDLE) begin
        conv_sr <= 6'h00;
      end else if (step && coded_phase && half) begin
        conv_sr <= window[6:1];
      end
    end
  end

  // ==========================================================
  // scrambler and output register
  // ==========================================================
  // every bit passes the scrambler, header and payload alike, with no bypass;
  // the sequence restarts while idle, so the first header bit meets the seed
  logic scr_bit;

  ptxfc_scrambler u_scr (
    .clk              (clk),
    .rst              (rst),
    .ce               (ce),
    .restart          (phase == ptxfc_pkg::PH_IDLE),
    .in_valid         (step),
    .in_bit           (coded_bit),
    .out_bit          (scr_bit),
    .pseudo_noise_seq ()
  );

  // field marks for the step in hand; the frame ends on the step that completes its last input bit
  logic next_is_header;
  logic next_frame_last;
  assign next_is_header  = (phase != ptxfc_pkg::PH_PAY) &&
                           (phase != ptxfc_pkg::PH_PAY_FLUSH) &&
                           (phase != ptxfc_pkg::PH_PAY_PAD);
  assign next_frame_last = bit_done && last_bit_of_phase &&
                           (next_phase == ptxfc_pkg::PH_IDLE);

  // registered data; the bit beside out_valid is the scrambled one, and it
  // stands until the next step so a stalled sink sees it unchanged
  always_ff @(posedge clk) begin
    if (rst) begin
      out_sym <= '0;
    end else if (ce && step) begin
      out_sym.bit_val    <= scr_bit;
      out_sym.is_header  <= next_is_header;
      out_sym.frame_last <= next_frame_last;
    end
  end

  // receive-side discard of reserved frames is not part of this transmit path
  // limitation: protocol and reserved header bits pass as plain source bits,
  // so reserved codes are the sender's to avoid

endmodule : ptxfc_frame_coder

/* bench/ptxfc_frame_coder_checker.sv */
`timescale 1ns/1ps
module ptxfc_frame_coder_checker (
  // clock, reset and control
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic                  ce,
  input wire logic                  start,
  input wire logic                  busy,
  // streams
  input wire logic                  src_valid,
  input wire logic                  src_bit,
  input wire logic                  src_ready,
  input wire ptxfc_pkg::ptxfc_sym_t out_sym,
  input wire logic                  out_valid,
  input wire logic                  out_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // one output step
  wire stp = ce && out_valid && out_ready;
  property p_idle; !busy |-> !src_ready && !out_valid; endproperty
  a_idle: assert property (p_idle) else $error("stream active while idle");
  property p_go; !busy && start && ce |=> busy; endproperty
  a_go: assert property (p_go) else $error("frame did not start");
  property p_hold; busy && !stp |=> $stable(out_sym); endproperty
  a_hold: assert property (p_hold) else $error("output moved without step");
  // first coded bit of a frame: zero encoder state and a zero first pn bit
  property p_first;
    $rose(busy) && stp |=> out_sym.bit_val == $past(src_bit) && out_sym.is_header && !src_ready;
  endproperty
  a_first: assert property (p_first) else $error("first coded bit wrong");
  property p_last; $rose(out_sym.frame_last) |-> ##[0:1] !busy; endproperty
  a_last: assert property (p_last) else $error("busy after last bit");
  // guard: a one-cycle reset would otherwise look like a frame end
  property p_fell; $fell(busy) && !$past(rst) |-> out_sym.frame_last; endproperty
  a_fell: assert property (p_fell) else $error("frame ended early");
  property p_ce; !ce |=> $stable(busy) && $stable(out_sym); endproperty
  a_ce: assert property (p_ce) else $error("moved with ce low");
  property p_ready; src_ready |-> out_valid == src_valid; endproperty
  a_ready: assert property (p_ready) else $error("valid not tied to source");
  c_start: cover property ($rose(busy));
  c_end: cover property ($rose(out_sym.frame_last));
  c_stall: cover property (busy && !out_ready);
endmodule : ptxfc_frame_coder_checker

bind ptxfc_frame_coder ptxfc_frame_coder_checker u_chk (
  .clk(clk), .rst(rst), .ce(ce), .start(start), .busy(busy), .src_valid(src_valid),
  .src_bit(src_bit), .src_ready(src_ready), .out_sym(out_sym), .out_valid(out_valid),
  .out_ready(out_ready));

/* bench/ptxfc_mac_model.sv */
`timescale 1ns/1ps
module ptxfc_mac_model (
  // control
  input  wire logic        clk,
  input  wire logic        ce,
  input  wire logic        busy,
  input  wire logic        stall,
  input  wire logic [15:0] n_bits,
  // source and sink
  input  wire logic        src_ready,
  output logic             src_valid,
  output logic             src_bit,
  output logic             src_last,
  output logic             out_ready
);
  logic [15:0] idx;
  logic        tk;
  initial begin
    idx = 16'h0;
    {src_valid, src_bit, src_last, out_ready} = 4'h1;
  end
  // advance just after the taking edge; a finished source shows an inverted bit
  always @(posedge clk) begin
    tk = src_valid && src_ready && ce;
    #1;
    idx = busy ? idx + 16'(tk) : 16'h0;
    src_valid = idx < n_bits;
    src_bit = src_valid ? ^(idx & 16'h00b3) : ~src_bit;
    src_last = idx == n_bits - 16'h1;
    out_ready = stall ? ~out_ready : 1'b1;
  end
endmodule : ptxfc_mac_model

/* bench/ptxfc_frame_coder_test.sv */
`timescale 1ns/1ps
module ptxfc_frame_coder_test;
  localparam int HL = 10;
  // settings beside the expected fragment and header pad lengths
  typedef struct packed {
    logic cc; logic [3:0] nch; logic [15:0] pad; logic [15:0] pay;
    logic [8:0] frag; logic [2:0] hpad; logic stl;
  } ptxfc_row_t;
  ptxfc_row_t rows [8] = '{
    '{1'h1, 4'h1, 16'h3, 16'h5, 9'h000, 3'h0, 1'h0}, '{1'h0, 4'h2, 16'h4, 16'h7, 9'h028, 3'h2, 1'h1},
    '{1'h1, 4'h3, 16'h0, 16'h9, 9'h050, 3'h4, 1'h0}, '{1'h1, 4'h4, 16'h5, 16'h6, 9'h078, 3'h6, 1'h1},
    '{1'h0, 4'h5, 16'h0, 16'h4, 9'h0a8, 3'h0, 1'h0}, '{1'h1, 4'h6, 16'h2, 16'h8, 9'h0d0, 3'h2, 1'h1},
    '{1'h0, 4'h7, 16'h1, 16'h3, 9'h0f8, 3'h4, 1'h0}, '{1'h1, 4'h8, 16'h7, 16'h2, 9'h120, 3'h6, 1'h0}};
  logic clk, rst, ce, start, slow, stp, stall;
  logic busy, src_valid, src_bit, src_last, src_ready, out_valid, out_ready;
  ptxfc_pkg::ptxfc_cfg_t cfg;
  ptxfc_pkg::ptxfc_sym_t out_sym;
  logic [15:0] n_bits;
  logic [1:0]  q [$];
  logic [6:0]  st, s;
  int          failures = 0, compares = 0, cyc = 0;
  ptxfc_frame_coder #(.HDR_INFO_LEN(HL)) u_ptxfc_frame_coder (.clk(clk), .rst(rst), .ce(ce),
    .start(start), .cfg(cfg), .busy(busy), .src_valid(src_valid), .src_bit(src_bit),
    .src_last(src_last), .src_ready(src_ready), .out_sym(out_sym), .out_valid(out_valid),
    .out_ready(out_ready));
  ptxfc_mac_model u_ptxfc_mac_model (.clk(clk), .ce(ce), .busy(busy), .stall(stall),
    .n_bits(n_bits), .src_ready(src_ready), .src_valid(src_valid), .src_bit(src_bit),
    .src_last(src_last), .out_ready(out_ready));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // hang guard, far above the longest frame set
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end
  task check(input logic [2:0] seen, input logic [2:0] want);
    compares++;
    if (seen !== want) begin
      failures++;
      $display("CHECK FAILED at %0t: got %b want %b", $time, seen, want);
    end
  endtask : check
  task wrap_up;
    if (failures == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  function logic f(input int i);
    return ^(i[15:0] & 16'h00b3);
  endfunction : f
  // reference scrambler, seven stages seeded with ones
  task push(input logic b, input logic h);
    logic pn;
    pn = s[3] ^ s[6];
    s = {s[5:0], pn};
    q.push_back({b ^ pn, h});
  endtask : push
  // reference coder, newest bit in the top stage
  task put(input logic b, input logic c, input logic h);
    if (c) begin
      st = {b, st[6:1]};
      push(^(st & 7'h79), h);
      push(^(st & 7'h5b), h);
    end else push(b, h);
  endtask : put
  task frame(input ptxfc_row_t r);
    int k;
    int j;
    st = 7'h00;
    s = 7'h7f;
    q.delete();
    k = 0;
    for (int i = 0; i < HL + r.frag; i++) put(f(i), 1'b1, 1'b1);
    for (int i = 0; i < 6 + r.hpad; i++) put(1'b0, 1'b1, 1'b1);
    for (int i = 0; i < r.pay; i++) put(f(HL + r.frag + i), r.cc, 1'b0);
    if (r.cc) for (int i = 0; i < 8; i++) put(1'b0, 1'b1, 1'b0);
    for (int i = 0; i < r.pad; i++) put(1'b0, r.cc, 1'b0);
    cfg = '{r.cc, r.nch, r.pad};
    n_bits = 16'(HL + r.frag + r.pay);
    stall = r.stl;
    start = 1'b1;
    // start stays high into the frame, where it must be ignored
    for (j = 0; k < q.size(); j++) begin
      @(negedge clk) stp = ce && out_valid && out_ready;
      @(posedge clk) #1;
      start = j < 2;
      ce = slow ? (j % 3 != 1) : 1'b1; // one low cycle in three, out of step with stall
      if (stp) begin
        check(out_sym, {q[k], k == q.size() - 1});
        k++;
      end
    end
    @(posedge clk) #1;
    check({busy, out_valid, 1'b0}, 3'h0);
  endtask : frame
  initial begin
    {rst, ce, start, slow, stall} = 5'h18;
    cfg = '0;
    n_bits = 16'h0;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    check({busy, out_valid, src_ready}, 3'h0);
    check(out_sym, 3'h0);
    foreach (rows[i]) frame(rows[i]);
    // reset in mid-frame, then a full frame at two-thirds clock-enable rate
    start = 1'b1;
    repeat (20) @(posedge clk);
    #1 rst = 1'b1;
    start = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    check({busy, out_valid, src_ready}, 3'h0);
    slow = 1'b1;
    frame(rows[3]);
    wrap_up();
  end
endmodule : ptxfc_frame_coder_test
